// ### include/usc_pkg.sv
// Shared constants and types of the serial status and control block.
package usc_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int BAUD_HZ = 6_250_000;
    localparam int BIT_CYC = CLK_HZ / BAUD_HZ;
    localparam int HALF_CYC = BIT_CYC / 2;
    localparam int TIM_W = 8;
    localparam int DEPTH = 4;
    localparam int BRK_ZEROS = 12;
    localparam logic [3:0] LEN_8N = 4'ha;
    localparam logic [3:0] LEN_9 = 4'hb;
    localparam logic [3:0] LEN_BRK = 4'(BRK_ZEROS + 2);
    localparam logic [7:0] OFS_STA = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_TXD = 8'h08;
    localparam logic [7:0] OFS_RXD = 8'h0c;
    localparam logic [7:0] OFS_IST = 8'h10;
    localparam logic [7:0] OFS_IMSK = 8'h14;
    localparam int B_TXISEL1 = 15;
    localparam int B_TXISEL0 = 13;
    localparam int B_BRK = 11;
    localparam int B_TXEN = 10;
    localparam int B_TXBF = 9;
    localparam int B_TX_ALL_EMPTY_FLAG = 8;
    localparam int B_RXISEL = 6;
    localparam int B_ADDRESS_DETECT_ENABLE = 5;
    localparam int B_RX_IDLE_FLAG = 4;
    localparam int B_PARITY_ERROR_FLAG = 3;
    localparam int B_FRAMING_ERROR_FLAG = 2;
    localparam int B_OVERRUN_FLAG = 1;
    localparam int B_RX_DATA_AVAILABLE_FLAG = 0;
    localparam int B_PDS = 1;
    localparam logic [1:0] TXI_EACH = 2'h0;
    localparam logic [1:0] TXI_DONE = 2'h1;
    localparam logic [1:0] TXI_EMPTY = 2'h2;
    localparam logic [1:0] RXI_FULL = 2'h3;
    localparam logic [1:0] RXI_3Q = 2'h2;
    localparam logic [1:0] PDS_9BIT = 2'h3;
    localparam logic [1:0] PDS_ODD = 2'h2;
    localparam logic [1:0] PDS_EVEN = 2'h1;
    localparam int IRQ_TX = 0;
    localparam int IRQ_RX = 1;
    localparam int IRQ_OVR = 2;
    localparam int IRQ_ERR = 3;
    localparam int IRQ_W = 4;
    typedef struct packed {
        logic framing_error_flag;
        logic parity_error_flag;
        logic [8:0] data;
    } usc_rx_char_t;
    typedef enum logic {USC_TX_IDLE, USC_TX_SHIFT} usc_tx_state_t;
    typedef enum logic {USC_RX_IDLE, USC_RX_BITS} usc_rx_state_t;
endpackage

// ### logic/usc_core.sv
// Serial status and control block with transmit and receive paths.
`timescale 1ns/1ns
module usc_core
    import usc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic serial_rx_pin,
    output logic serial_tx_pin,
    output logic serial_tx_drive,
    output logic irq
);
    // ----------------------------------------
    // State.
    // ----------------------------------------
    logic tx_en, brk, address_detect_enable, overrun_flag, ack, tx_is_brk, rx_s1, rx_s2;
    logic [1:0] txisel, rxisel, pds;
    logic [IRQ_W-1:0] ist, msk;
    logic [8:0] txq [DEPTH];
    logic [1:0] tx_wp, tx_rp, rx_wp, rx_rp;
    logic [2:0] tx_cnt, rx_cnt;
    usc_tx_state_t tx_st;
    usc_rx_state_t rx_st;
    logic [13:0] tx_sh;
    logic [3:0] tx_left, rx_left;
    logic [TIM_W-1:0] tx_tim, rx_tim;
    logic [10:0] rx_sh;
    usc_rx_char_t rxq [DEPTH];
    logic [31:0] rdata;
    logic next_tx_en, next_brk, next_address_detect_enable, next_overrun_flag, next_ack, next_tx_is_brk, next_pin;
    logic [1:0] next_txisel, next_rxisel, next_pds;
    logic [IRQ_W-1:0] next_ist, next_msk;
    logic [8:0] next_txq [DEPTH];
    logic [1:0] next_tx_wp, next_tx_rp, next_rx_wp, next_rx_rp;
    logic [2:0] next_tx_cnt, next_rx_cnt;
    usc_tx_state_t next_tx_st;
    usc_rx_state_t next_rx_st;
    logic [13:0] next_tx_sh;
    logic [3:0] next_tx_left, next_rx_left;
    logic [TIM_W-1:0] next_tx_tim, next_rx_tim;
    logic [10:0] next_rx_sh, nsh, fr;
    usc_rx_char_t next_rxq [DEPTH];
    usc_rx_char_t head, got;
    logic [31:0] next_rdata;
    logic [15:0] sta;
    logic [8:0] td;
    logic [IRQ_W-1:0] ev;
    logic go, wr_sta, rd_ist, rx_done, rx_store, short;

    // ----------------------------------------
    // Status view and bus handshake.
    // ----------------------------------------
    assign head = rxq[rx_rp];
    assign go = (avs_read | avs_write) & ack;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign avs_readdata = rdata;
    assign serial_tx_drive = tx_en;
    assign wr_sta = go & avs_write & (avs_address == OFS_STA);
    assign rd_ist = go & avs_read & (avs_address == OFS_IST);

    always_comb begin
        sta = '0;
        sta[B_TXISEL1] = txisel[1];
        sta[B_TXISEL0] = txisel[0];
        sta[B_BRK] = brk;
        sta[B_TXEN] = tx_en;
        sta[B_TXBF] = (tx_cnt == 3'(DEPTH));
        sta[B_TX_ALL_EMPTY_FLAG] = (tx_st == USC_TX_IDLE) & (tx_cnt == 3'h0) & ~brk;
        sta[B_RXISEL+:2] = rxisel;
        sta[B_ADDRESS_DETECT_ENABLE] = address_detect_enable;
        sta[B_RX_IDLE_FLAG] = (rx_st == USC_RX_IDLE);
        sta[B_PARITY_ERROR_FLAG] = (rx_cnt != 3'h0) & head.parity_error_flag;
        sta[B_FRAMING_ERROR_FLAG] = (rx_cnt != 3'h0) & head.framing_error_flag;
        sta[B_OVERRUN_FLAG] = overrun_flag;
        sta[B_RX_DATA_AVAILABLE_FLAG] = (rx_cnt != 3'h0);
    end

    // ----------------------------------------
    // Next state of the whole block.
    // ----------------------------------------
    always_comb begin
        next_tx_en = tx_en;
        next_brk = brk;
        next_address_detect_enable = address_detect_enable;
        next_overrun_flag = overrun_flag;
        next_txisel = txisel;
        next_rxisel = rxisel;
        next_pds = pds;
        next_msk = msk;
        next_txq = txq;
        next_tx_wp = tx_wp;
        next_tx_rp = tx_rp;
        next_tx_cnt = tx_cnt;
        next_tx_st = tx_st;
        next_tx_sh = tx_sh;
        next_tx_left = tx_left;
        next_tx_tim = tx_tim;
        next_tx_is_brk = tx_is_brk;
        next_rxq = rxq;
        next_rx_wp = rx_wp;
        next_rx_rp = rx_rp;
        next_rx_cnt = rx_cnt;
        next_rx_st = rx_st;
        next_rx_sh = rx_sh;
        next_rx_left = rx_left;
        next_rx_tim = rx_tim;
        next_ack = (avs_read | avs_write) & ~ack;
        next_rdata = rdata;
        ev = '0;
        td = '0;
        got = '0;
        rx_done = 1'b0;
        rx_store = 1'b0;
        short = (pds == 2'h0);
        nsh = {rx_s2, rx_sh[10:1]};
        fr = nsh;
        if (avs_read & ~ack) begin
            case (avs_address)
                OFS_STA: next_rdata = {16'h0, sta};
                OFS_MODE: next_rdata = 32'({pds, 1'b0});
                OFS_RXD: next_rdata = 32'(head.data);
                OFS_IST: next_rdata = 32'(ist);
                OFS_IMSK: next_rdata = 32'(msk);
                default: next_rdata = 32'h0;
            endcase
        end
        // Transmit shifter.
        if (tx_st == USC_TX_SHIFT) begin
            if (tx_tim != '0) begin
                next_tx_tim = tx_tim - 1'b1;
            end else if (tx_left == 4'h1) begin
                next_tx_st = USC_TX_IDLE;
                if (tx_is_brk) begin
                    next_brk = 1'b0;
                end
                next_tx_is_brk = 1'b0;
                if (txisel == TXI_DONE && tx_cnt == 3'h0 && !brk) begin
                    ev[IRQ_TX] = 1'b1;
                end
            end else begin
                next_tx_tim = TIM_W'(BIT_CYC - 1);
                next_tx_left = tx_left - 1'b1;
                next_tx_sh = {1'b1, tx_sh[13:1]};
            end
        end else if (tx_en) begin
            // break frame of start, zeros, stop
            if (brk) begin
                next_tx_st = USC_TX_SHIFT;
                next_tx_is_brk = 1'b1;
                next_tx_sh = 14'(1) << (LEN_BRK - 4'h1);
                next_tx_left = LEN_BRK;
                next_tx_tim = TIM_W'(BIT_CYC - 1);
            end else if (tx_cnt != 3'h0) begin
                td = txq[tx_rp];
                next_tx_st = USC_TX_SHIFT;
                next_tx_rp = tx_rp + 1'b1;
                next_tx_cnt = tx_cnt - 1'b1;
                next_tx_tim = TIM_W'(BIT_CYC - 1);
                case (pds)
                    PDS_9BIT: next_tx_sh = {4'h1, td, 1'b0};
                    PDS_ODD: next_tx_sh = {4'h1, ~^td[7:0], td[7:0], 1'b0};
                    PDS_EVEN: next_tx_sh = {4'h1, ^td[7:0], td[7:0], 1'b0};
                    default: next_tx_sh = {5'h1, td[7:0], 1'b0};
                endcase
                next_tx_left = short ? LEN_8N : LEN_9;
                if (txisel == TXI_EACH || (txisel == TXI_EMPTY && tx_cnt == 3'h1)) begin
                    ev[IRQ_TX] = 1'b1;
                end
            end
        end
        if (go && avs_write && avs_address == OFS_TXD && tx_en && tx_cnt != 3'(DEPTH)) begin
            next_txq[tx_wp] = avs_writedata[8:0];
            next_tx_wp = tx_wp + 1'b1;
            next_tx_cnt = next_tx_cnt + 1'b1;
        end
        // Receiver.
        if (rx_st == USC_RX_IDLE) begin
            if (!rx_s2) begin
                next_rx_st = USC_RX_BITS;
                next_rx_tim = TIM_W'(HALF_CYC);
                next_rx_left = short ? LEN_8N : LEN_9;
                next_rx_sh = '0;
            end
        end else if (rx_tim != '0) begin
            next_rx_tim = rx_tim - 1'b1;
        end else if (rx_left == (short ? LEN_8N : LEN_9) && rx_s2) begin
            next_rx_st = USC_RX_IDLE;
        end else begin
            next_rx_tim = TIM_W'(BIT_CYC - 1);
            next_rx_left = rx_left - 1'b1;
            next_rx_sh = nsh;
            if (rx_left == 4'h1) begin
                next_rx_st = USC_RX_IDLE;
                rx_done = 1'b1;
            end
        end
        if (rx_done) begin
            if (short) begin
                fr = {1'b0, nsh[10:1]};
            end
            got.data = {(pds == PDS_9BIT) & fr[9], fr[8:1]};
            got.parity_error_flag = (pds == PDS_ODD && fr[9] == ^fr[8:1]) ||
                (pds == PDS_EVEN && fr[9] != ^fr[8:1]);
            got.framing_error_flag = short ? ~fr[9] : ~fr[10];
            rx_store = !(address_detect_enable && pds == PDS_9BIT && !got.data[8]);
        end
        if (rx_store) begin
            if (rx_cnt == 3'(DEPTH) || overrun_flag) begin
                ev[IRQ_OVR] = ~overrun_flag;
                next_overrun_flag = 1'b1;
            end else begin
                next_rxq[rx_wp] = got;
                next_rx_wp = rx_wp + 1'b1;
                next_rx_cnt = rx_cnt + 1'b1;
                ev[IRQ_ERR] = got.parity_error_flag | got.framing_error_flag;
                case (rxisel)
                    RXI_FULL: ev[IRQ_RX] = (rx_cnt == 3'(DEPTH - 1));
                    RXI_3Q: ev[IRQ_RX] = (rx_cnt == 3'(DEPTH - 2));
                    default: ev[IRQ_RX] = 1'b1;
                endcase
            end
        end
        if (go && avs_read && avs_address == OFS_RXD && rx_cnt != 3'h0) begin
            next_rx_rp = rx_rp + 1'b1;
            next_rx_cnt = next_rx_cnt - 1'b1;
        end
        // Register writes.
        // read-only flags ignore writes
        if (wr_sta && avs_byteenable[1]) begin
            next_txisel = {avs_writedata[B_TXISEL1], avs_writedata[B_TXISEL0]};
            next_tx_en = avs_writedata[B_TXEN];
            next_brk = avs_writedata[B_BRK] | next_brk;
        end
        if (wr_sta && avs_byteenable[0]) begin
            next_rxisel = avs_writedata[B_RXISEL+:2];
            next_address_detect_enable = avs_writedata[B_ADDRESS_DETECT_ENABLE];
            if (overrun_flag && !avs_writedata[B_OVERRUN_FLAG]) begin
                next_overrun_flag = ev[IRQ_OVR];
                next_rx_cnt = 3'h0;
                next_rx_rp = 2'h0;
                next_rx_wp = 2'h0;
                next_rx_st = USC_RX_IDLE;
            end
        end
        if (go && avs_write && avs_address == OFS_MODE && avs_byteenable[0]) begin
            next_pds = avs_writedata[B_PDS+:2];
        end
        if (go && avs_write && avs_address == OFS_IMSK && avs_byteenable[0]) begin
            next_msk = avs_writedata[IRQ_W-1:0];
        end
        if (!next_tx_en) begin
            next_tx_cnt = 3'h0;
            next_tx_rp = 2'h0;
            next_tx_wp = 2'h0;
            next_tx_st = USC_TX_IDLE;
            next_tx_is_brk = 1'b0;
            next_brk = 1'b0;
        end
        next_ist = (ist & ~(rd_ist ? rdata[IRQ_W-1:0] : '0)) | ev;
        next_pin = (next_tx_st == USC_TX_SHIFT) ? next_tx_sh[0] : 1'b1;
    end

    always_ff @(posedge clk) begin
        rx_s1 <= serial_rx_pin;
        rx_s2 <= rx_s1;
        txq <= next_txq;
        rxq <= next_rxq;
        tx_sh <= next_tx_sh;
        rx_sh <= next_rx_sh;
        tx_left <= next_tx_left;
        rx_left <= next_rx_left;
        tx_tim <= next_tx_tim;
        rx_tim <= next_rx_tim;
        rdata <= next_rdata;
        if (srst) begin
            tx_en <= 1'b0;
            brk <= 1'b0;
            address_detect_enable <= 1'b0;
            overrun_flag <= 1'b0;
            ack <= 1'b0;
            tx_is_brk <= 1'b0;
            txisel <= 2'h0;
            rxisel <= 2'h0;
            pds <= 2'h0;
            ist <= '0;
            msk <= '0;
            tx_wp <= 2'h0;
            tx_rp <= 2'h0;
            rx_wp <= 2'h0;
            rx_rp <= 2'h0;
            tx_cnt <= 3'h0;
            rx_cnt <= 3'h0;
            tx_st <= USC_TX_IDLE;
            rx_st <= USC_RX_IDLE;
            serial_tx_pin <= 1'b1;
            irq <= 1'b0;
        end else begin
            tx_en <= next_tx_en;
            brk <= next_brk;
            address_detect_enable <= next_address_detect_enable;
            overrun_flag <= next_overrun_flag;
            ack <= next_ack;
            tx_is_brk <= next_tx_is_brk;
            txisel <= next_txisel;
            rxisel <= next_rxisel;
            pds <= next_pds;
            ist <= next_ist;
            msk <= next_msk;
            tx_wp <= next_tx_wp;
            tx_rp <= next_tx_rp;
            rx_wp <= next_rx_wp;
            rx_rp <= next_rx_rp;
            tx_cnt <= next_tx_cnt;
            rx_cnt <= next_rx_cnt;
            tx_st <= next_tx_st;
            rx_st <= next_rx_st;
            serial_tx_pin <= next_pin;
            irq <= |(next_ist & next_msk);
        end
    end

    // ----------------------------------------
    // Checks.
    // ----------------------------------------
    property p_brk_low;
        @(posedge clk) disable iff (srst) $rose(tx_is_brk) |-> !serial_tx_pin [*8];
    endproperty
    a_brk_low: assert property (p_brk_low) else $error("break not low");
    property p_brk_clr;
        @(posedge clk) disable iff (srst) $fell(tx_is_brk) |-> !brk;
    endproperty
    a_brk_clr: assert property (p_brk_clr) else $error("break bit stuck");
    property p_drive;
        @(posedge clk) disable iff (srst) tx_st == USC_TX_SHIFT |-> serial_tx_drive;
    endproperty
    a_drive: assert property (p_drive) else $error("shifting undriven");
    property p_abort;
        @(posedge clk) disable iff (srst) !tx_en |-> tx_cnt == 3'h0 && tx_st == USC_TX_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("abort failed");
    property p_tx_all_empty_flag;
        @(posedge clk) disable iff (srst) tx_cnt != 3'h0 |-> !sta[B_TX_ALL_EMPTY_FLAG];
    endproperty
    a_tx_all_empty_flag: assert property (p_tx_all_empty_flag) else $error("empty flag wrong");
    property p_rx4;
        @(posedge clk) disable iff (srst)
            rx_store && !overrun_flag && rxisel == RXI_FULL && rx_cnt == 3'h3 |=> ist[IRQ_RX];
    endproperty
    a_rx4: assert property (p_rx4) else $error("no full interrupt");
    property p_rx_idle_flag;
        @(posedge clk) disable iff (srst) $fell(rx_s2) && sta[B_RX_IDLE_FLAG] |=> !sta[B_RX_IDLE_FLAG];
    endproperty
    a_rx_idle_flag: assert property (p_rx_idle_flag) else $error("idle flag stuck");
    property p_flush;
        @(posedge clk) disable iff (srst)
            wr_sta && avs_byteenable[0] && overrun_flag && !avs_writedata[B_OVERRUN_FLAG] |=> rx_cnt == 3'h0;
    endproperty
    a_flush: assert property (p_flush) else $error("overrun clear no flush");
    property p_avail;
        @(posedge clk) disable iff (srst) rx_store && rx_cnt == 3'h0 && !overrun_flag |=> sta[B_RX_DATA_AVAILABLE_FLAG];
    endproperty
    a_avail: assert property (p_avail) else $error("data flag low");
endmodule

// ### tb/tb.sv
// Self-checking bench of the serial status and control block.
`timescale 1ns/1ns
module tb
    import usc_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic serial_rx_pin;
    logic serial_tx_pin;
    logic serial_tx_drive;
    logic irq;
    logic [15:0] ctl = 16'h0;
    logic [31:0] rd;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    usc_core i_dut (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
        .serial_tx_drive(serial_tx_drive), .irq(irq));
    usc_line_model i_line (.clk(clk), .tx_pin(serial_tx_pin), .tx_drive(serial_tx_drive),
        .rx_pin(serial_rx_pin));

    // ----------------------------------------
    // Shared tasks.
    // ----------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count++;
            results();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest) @(posedge clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        bus(1'b1, a, {16'h0, v});
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd[15:0], e);
    endtask
    task automatic wait_sta(input int b, input logic v);
        bus(1'b0, OFS_STA, 32'h0);
        while (rd[b] !== v) bus(1'b0, OFS_STA, 32'h0);
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // ----------------------------------------
    // Scenarios.
    // ----------------------------------------
    task automatic t_reset();
        rdchk(OFS_STA, 16'h0110);
        chk({14'h0, serial_tx_drive, serial_tx_pin}, 16'h0001);
        $display("test reset done");
    endtask
    task automatic t_tx();
        ctl = 16'h2400;
        wr(OFS_IMSK, 16'h0001);
        wr(OFS_STA, ctl);
        pause(2);
        chk({15'h0, serial_tx_drive}, 16'h0001);
        for (int i = 0; i < 6; i++) wr(OFS_TXD, 16'h0041 + 16'(i));
        rdchk(OFS_STA, ctl | 16'h0210);
        chk({15'h0, irq}, 16'h0000);
        wait_sta(B_TX_ALL_EMPTY_FLAG, 1'b1);
        pause(3);
        chk({15'h0, irq}, 16'h0001);
        chk(16'(i_line.got_q.size()), 16'h0005);
        for (int i = 0; i < 5; i++) chk({8'h0, i_line.got_q[i]}, 16'h0041 + 16'(i));
        i_line.got_q.delete();
        rdchk(OFS_IST, 16'h0001);
        wr(OFS_IMSK, 16'h0000);
        ctl = 16'h0400;
        wr(OFS_STA, ctl);
        $display("test transmit done");
    endtask
    task automatic t_abort();
        for (int i = 0; i < 3; i++) wr(OFS_TXD, 16'h0061);
        repeat (40) @(posedge clk);
        wr(OFS_STA, 16'h0000);
        rdchk(OFS_STA, 16'h0110);
        pause(2);
        chk({14'h0, serial_tx_drive, serial_tx_pin}, 16'h0001);
        pause(300);
        i_line.got_q.delete();
        wr(OFS_STA, ctl);
        $display("test abort done");
    endtask
    task automatic t_break();
        wr(OFS_STA, ctl | 16'h0800);
        wait_sta(B_BRK, 1'b0);
        pause(20);
        chk(16'(i_line.zeros), 16'h000c);
        rdchk(OFS_STA, ctl | 16'h0110);
        i_line.got_q.delete();
        $display("test break done");
    endtask
    task automatic t_rxirq(input logic [1:0] sel, input int n);
        ctl = 16'h0400 | {8'h0, sel, 6'h0};
        wr(OFS_STA, ctl);
        wr(OFS_IMSK, 16'h0002);
        bus(1'b0, OFS_IST, 32'h0);
        for (int i = 0; i < n; i++) begin
            pause(2);
            chk({15'h0, irq}, 16'h0000);
            fork
                i_line.send({3'b111, 8'h30 + 8'(i)}, 9);
                if (i == 0) begin
                    repeat (40) @(posedge clk);
                    rdchk(OFS_STA, ctl | 16'h0100);
                end
            join
        end
        pause(3);
        chk({15'h0, irq}, 16'h0001);
        rdchk(OFS_IST, 16'h0002);
        for (int i = 0; i < n; i++) rdchk(OFS_RXD, 16'h0030 + 16'(i));
        rdchk(OFS_STA, ctl | 16'h0110);
        $display("test receive irq %0d done", sel);
    endtask
    task automatic t_err();
        wr(OFS_MODE, {13'h0, PDS_EVEN, 1'b0});
        i_line.send({1'b1, 1'b0, 8'h01}, 10);
        i_line.send({1'b0, 1'b0, 8'h03}, 10);
        pause(20);
        rdchk(OFS_STA, ctl | 16'h0119);
        rdchk(OFS_RXD, 16'h0001);
        rdchk(OFS_STA, ctl | 16'h0115);
        rdchk(OFS_RXD, 16'h0003);
        rdchk(OFS_STA, ctl | 16'h0110);
        wr(OFS_MODE, 16'h0000);
        bus(1'b0, OFS_IST, 32'h0);
        $display("test errors done");
    endtask
    task automatic t_ovr();
        ctl = 16'h0400;
        wr(OFS_STA, ctl);
        for (int i = 0; i < 5; i++) i_line.send({3'b111, 8'h50 + 8'(i)}, 9);
        pause(20);
        rdchk(OFS_STA, ctl | 16'h0113);
        wr(OFS_STA, ctl | 16'h0003);
        rdchk(OFS_STA, ctl | 16'h0113);
        wr(OFS_STA, ctl | 16'h0001);
        rdchk(OFS_STA, ctl | 16'h0110);
        bus(1'b0, OFS_IST, 32'h0);
        $display("test overrun done");
    endtask
    task automatic t_addr();
        wr(OFS_MODE, {13'h0, PDS_9BIT, 1'b0});
        ctl = 16'h0420;
        wr(OFS_STA, ctl);
        i_line.send({2'b01, 9'h055}, 10);
        pause(20);
        rdchk(OFS_STA, ctl | 16'h0110);
        i_line.send({2'b01, 9'h1a5}, 10);
        pause(20);
        rdchk(OFS_STA, ctl | 16'h0111);
        rdchk(OFS_RXD, 16'h01a5);
        wr(OFS_MODE, 16'h0000);
        i_line.send({3'b111, 8'h66}, 9);
        pause(20);
        rdchk(OFS_RXD, 16'h0066);
        $display("test address detect done");
    endtask

    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_tx();
        t_abort();
        t_break();
        t_rxirq(2'h0, 1);
        t_rxirq(2'h1, 1);
        t_rxirq(RXI_3Q, 3);
        t_rxirq(RXI_FULL, 4);
        t_err();
        t_ovr();
        t_addr();
        results();
    end
endmodule

// ### tb/usc_line_model.sv
// Remote serial transceiver model that faces the block on the line.
`timescale 1ns/1ns
module usc_line_model
    import usc_pkg::*;
(
    input wire logic clk,
    input wire logic tx_pin,
    input wire logic tx_drive,
    output logic rx_pin
);
    logic [7:0] got_q[$];
    logic [7:0] d;
    int zeros;
    int run;

    // ----------------------------------------
    // Sender: start bit, then n bits of b LSB first; b holds parity and stop.
    // ----------------------------------------
    initial rx_pin = 1'b1;
    task automatic send(input logic [10:0] b, input int n);
        @(posedge clk) rx_pin <= 1'b0;
        repeat (BIT_CYC - 1) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            @(posedge clk) rx_pin <= b[i];
            repeat (BIT_CYC - 1) @(posedge clk);
        end
        @(posedge clk) rx_pin <= 1'b1;
    endtask

    // ----------------------------------------
    // Receiver: samples mid-bit, keeps data and the run of low bits after start.
    // ----------------------------------------
    always begin
        @(negedge tx_pin);
        if (tx_drive) begin
            repeat (HALF_CYC) @(posedge clk);
            run = 0;
            for (int i = 0; i < 13; i++) begin
                repeat (BIT_CYC) @(posedge clk);
                if (i < 8) d[i] = tx_pin;
                if (!tx_pin && run == i) run++;
                if (tx_pin && i >= 8) break;
            end
            zeros = run;
            got_q.push_back(d);
        end
    end
endmodule
